//--- pkg/spisf_pkg.sv
// Purpose: Constants and types for the SPI status, flag and data register block
// Assumes: APB slave with 32-bit data, one aligned word per register
// Notes: Offsets are word byte addresses
package spisf_pkg;
	localparam logic [11:0] SPISF_OFF_CTRL = 12'h000;
	localparam logic [11:0] SPISF_OFF_STAT = 12'h004;
	localparam logic [11:0] SPISF_OFF_DATA = 12'h008;
	// Control register bit positions
	localparam int SPISF_C_RXIE = 7;
	localparam int SPISF_C_MSTR = 5;
	localparam int SPISF_C_CPOL = 4;
	localparam int SPISF_C_CPHA = 3;
	localparam int SPISF_C_WOM = 2;
	localparam int SPISF_C_EN = 1;
	localparam int SPISF_C_TXIE = 0;
	// Status and control register bit positions
	localparam int SPISF_S_RXF = 7;
	localparam int SPISF_S_ERROR_IRQ_ENABLE = 6;
	localparam int SPISF_S_OVR = 5;
	localparam int SPISF_S_MODE_FAULT_FLAG = 4;
	localparam int SPISF_S_TXE = 3;
	localparam int SPISF_S_MFEN = 2;
	localparam int SPISF_S_RATE_HI = 1;
	localparam int SPISF_S_RATE_LO = 0;
	localparam logic [7:0] SPISF_CTRL_RST = 8'h28;
	localparam logic [7:0] SPISF_STAT_CFG_RST = 8'h00;
	// Baud divisors for rate field 00..11
	localparam logic [7:0] SPISF_BD_0 = 8'h02;
	localparam logic [7:0] SPISF_BD_1 = 8'h08;
	localparam logic [7:0] SPISF_BD_2 = 8'h20;
	localparam logic [7:0] SPISF_BD_3 = 8'h80;

	typedef struct packed {
		logic [7:0] ctrl;
		logic error_irq_enable;
		logic mfen;
		logic [1:0] rate;
		logic rxf;
		logic ovr;
		logic mode_fault_flag;
		logic txe;
		logic rxf_arm;
		logic ovr_arm;
		logic mode_fault_flag_arm;
		logic [7:0] rx_buf;
		logic [7:0] tx_buf;
		logic tx_load;
		logic [7:0] tx_load_data;
		logic [6:0] div_cnt;
		logic sck_tick;
		logic ss_q;
		logic ss_owned;
		logic is_slave;
		logic irq;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} spisf_state_t;
endpackage : spisf_pkg

//--- testbench/spi_status_flags_and_data_bench.sv
// Purpose: Register-level bench for the SPI flag block
// Assumes: Zero-wait APB slave, stand-in shifter on the far side
// Notes: Expected register values follow the control and status layout
module spi_status_flags_and_data_bench import spisf_pkg::*;;
	timeunit 1ns / 1ns;
	logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata;
	logic pready, pslverr, ss_n, act, done, take, txv, sck, owned, smode, irq;
	logic [7:0] rxb, txb, ctrl_o;
	int n_fail = 0, compares = 0, n;
	always #25 pclk = ~pclk;
	spisf_core spisf_core_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .slave_select_n(ss_n), .transfer_active(act),
		.rx_byte_done(done), .rx_byte(rxb), .tx_take(take), .tx_byte(txb), .tx_byte_valid(txv),
		.sck_tick(sck), .ss_pin_owned(owned), .slave_mode(smode), .irq(irq), .ctrl_out(ctrl_o));
	spisf_far_end spisf_far_end_inst (.pclk(pclk), .slave_select_n(ss_n), .transfer_active(act),
		.rx_byte_done(done), .rx_byte(rxb), .tx_take(take));
	task automatic final_report();
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// One APB transfer; reads compare against d
	task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
		n = 0;
		@(posedge pclk);
		{psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		{psel, penable} <= 2'b00;
		err = pslverr;
		if (n >= 16) begin
			n_fail++;
			final_report();
		end
		if (!w) chk($sformatf("reg %h", a), d, prdata);
		repeat (2) @(posedge pclk);
	endtask : xfer
	initial begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		xfer(1'b0, SPISF_OFF_CTRL, 32'(SPISF_CTRL_RST));
		xfer(1'b0, SPISF_OFF_STAT, 32'h08);
		xfer(1'b1, SPISF_OFF_CTRL, 32'h02);
		spisf_far_end_inst.select(1'b0, 1'b0);
		chk("slave_mode", 32'h1, 32'(smode));
		chk("ss_owned", 32'h1, 32'(owned));
		xfer(1'b1, SPISF_OFF_DATA, 32'hA5);
		chk("tx_valid", 32'h1, 32'(txv));
		xfer(1'b0, SPISF_OFF_STAT, 32'h00);
		spisf_far_end_inst.exchange(8'h3C);
		chk("tx_byte", 32'hA5, 32'(txb));
		chk("tx_valid", 32'h0, 32'(txv));
		xfer(1'b0, SPISF_OFF_STAT, 32'h88);
		chk("irq", 32'h0, 32'(irq));
		xfer(1'b1, SPISF_OFF_CTRL, 32'h82);
		chk("irq", 32'h1, 32'(irq));
		xfer(1'b1, SPISF_OFF_CTRL, 32'h02);
		spisf_far_end_inst.exchange(8'h77);
		chk("irq", 32'h0, 32'(irq));
		xfer(1'b1, SPISF_OFF_STAT, 32'h40);
		chk("irq", 32'h1, 32'(irq));
		xfer(1'b0, SPISF_OFF_STAT, 32'hE8);
		xfer(1'b0, SPISF_OFF_DATA, 32'h3C);
		xfer(1'b0, SPISF_OFF_STAT, 32'h48);
		xfer(1'b1, SPISF_OFF_STAT, 32'h44);
		spisf_far_end_inst.select(1'b1, 1'b1);
		xfer(1'b0, SPISF_OFF_STAT, 32'h5C);
		xfer(1'b1, SPISF_OFF_STAT, 32'h40);
		xfer(1'b0, SPISF_OFF_STAT, 32'h58);
		xfer(1'b1, SPISF_OFF_CTRL, 32'h22);
		chk("ctrl_out", 32'h22, 32'(ctrl_o));
		xfer(1'b0, SPISF_OFF_STAT, 32'h48);
		spisf_far_end_inst.select(1'b0, 1'b0);
		xfer(1'b0, SPISF_OFF_STAT, 32'h48);
		chk("ss_owned", 32'h0, 32'(owned));
		spisf_far_end_inst.select(1'b1, 1'b0);
		xfer(1'b1, SPISF_OFF_STAT, 32'h44);
		spisf_far_end_inst.select(1'b0, 1'b0);
		xfer(1'b0, SPISF_OFF_STAT, 32'h5C);
		chk("ss_owned", 32'h1, 32'(owned));
		xfer(1'b0, 12'h00C, 32'h0);
		chk("pslverr", 32'h1, 32'(err));
		// Tick spacing per rate code, after two ticks to settle
		for (int k = 0; k < 4; k++) begin
			xfer(1'b1, SPISF_OFF_STAT, 32'(k));
			repeat (3) begin
				n = 0;
				do begin
					@(posedge pclk);
					n++;
				end while (sck !== 1'b1 && n < 300);
			end
			chk("divisor", 32'(2 << (2 * k)), 32'(n));
		end
		final_report();
	end
endmodule : spi_status_flags_and_data_bench

//--- testbench/spisf_far_end.sv
// Purpose: Shifter and remote device stand-in for the SPI flag block
// Assumes: Strobes and select change just after a bus clock edge
// Notes: Receive data shows the inverse byte outside its strobe
module spisf_far_end (
	input wire logic pclk,
	output logic slave_select_n,
	output logic transfer_active,
	output logic rx_byte_done,
	output logic [7:0] rx_byte,
	output logic tx_take
);
	timeunit 1ns / 1ns;
	initial {slave_select_n, transfer_active, rx_byte_done, rx_byte, tx_take} = 12'h800;
	// Full-duplex byte: take the waiting byte, return one after eight cycles
	task automatic exchange(input logic [7:0] b);
		@(posedge pclk);
		{tx_take, transfer_active} <= 2'b11;
		@(posedge pclk);
		tx_take <= 1'b0;
		repeat (7) @(posedge pclk);
		{rx_byte_done, rx_byte, transfer_active} <= {1'b1, b, 1'b0};
		@(posedge pclk);
		{rx_byte_done, rx_byte} <= {1'b0, ~b};
		repeat (3) @(posedge pclk);
	endtask : exchange
	// Select change, optionally in mid-transfer
	task automatic select(input logic lvl, input logic busy);
		@(posedge pclk);
		transfer_active <= busy;
		@(posedge pclk);
		slave_select_n <= lvl;
		@(posedge pclk);
		transfer_active <= 1'b0;
		repeat (3) @(posedge pclk);
	endtask : select
endmodule : spisf_far_end

//--- verilog/spisf_core.sv
// Purpose: Flags, interrupt request, baud tick and data buffers of an SPI port
// Assumes: Shift engine outside gives byte-done and tx-take strobes, inputs synchronous
// Notes: APB slave answers in the access cycle, zero wait states
//
// Implementation choices: the placing of the registers and the APB slave port.
module spisf_core
	import spisf_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic slave_select_n,
	input wire logic transfer_active,
	input wire logic rx_byte_done,
	input wire logic [7:0] rx_byte,
	input wire logic tx_take,
	output logic [7:0] tx_byte,
	output logic tx_byte_valid,
	output logic sck_tick,
	output logic ss_pin_owned,
	output logic slave_mode,
	output logic irq,
	output logic [7:0] ctrl_out
);
	spisf_state_t s_q, s_d;
	logic setup, acc, wr, rd, hit_c, hit_s, hit_d;
	logic en, mstr, set_rxf, set_ovr, set_mode_fault_flag, set_txe, clr_rxf, clr_ovr, clr_mode_fault_flag;
	logic [7:0] bd, stat_rd;

	assign setup = psel && !penable;
	assign acc = psel && penable;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign hit_c = paddr == SPISF_OFF_CTRL;
	assign hit_s = paddr == SPISF_OFF_STAT;
	assign hit_d = paddr == SPISF_OFF_DATA;
	assign en = s_q.ctrl[SPISF_C_EN];
	assign mstr = s_q.ctrl[SPISF_C_MSTR];

	always_comb begin
		unique case (s_q.rate)
			2'b00: bd = SPISF_BD_0;
			2'b01: bd = SPISF_BD_1;
			2'b10: bd = SPISF_BD_2;
			2'b11: bd = SPISF_BD_3;
		endcase
	end

	always_comb begin
		stat_rd = '0;
		stat_rd[SPISF_S_RXF] = s_q.rxf;
		stat_rd[SPISF_S_ERROR_IRQ_ENABLE] = s_q.error_irq_enable;
		stat_rd[SPISF_S_OVR] = s_q.ovr;
		stat_rd[SPISF_S_MODE_FAULT_FLAG] = s_q.mode_fault_flag;
		stat_rd[SPISF_S_TXE] = s_q.txe;
		stat_rd[SPISF_S_MFEN] = s_q.mfen;
		stat_rd[SPISF_S_RATE_HI] = s_q.rate[1];
		stat_rd[SPISF_S_RATE_LO] = s_q.rate[0];
	end

	// Flag set and clear terms
	assign set_rxf = rx_byte_done && !s_q.rxf;
	assign set_ovr = rx_byte_done && s_q.rxf;
	assign set_mode_fault_flag = en && s_q.mfen && (
		(!mstr && transfer_active && slave_select_n) ||
		(mstr && !slave_select_n));
	assign set_txe = tx_take && s_q.tx_load;
	assign clr_rxf = rd && hit_d && s_q.rxf_arm;
	assign clr_ovr = rd && hit_d && s_q.ovr_arm;
	assign clr_mode_fault_flag = wr && hit_c && s_q.mode_fault_flag_arm;

	always_comb begin
		s_d = s_q;
		s_d.pready = setup;
		s_d.pslverr = setup && !(hit_c || hit_s || hit_d);
		s_d.prdata = '0;
		if (setup && !pwrite) begin
			if (hit_c) s_d.prdata[7:0] = s_q.ctrl;
			if (hit_s) s_d.prdata[7:0] = stat_rd;
			if (hit_d) s_d.prdata[7:0] = s_q.rx_buf;
		end
		if (wr && hit_c && pstrb[0]) s_d.ctrl = pwdata[7:0];
		if (wr && hit_s && pstrb[0]) begin
			s_d.error_irq_enable = pwdata[SPISF_S_ERROR_IRQ_ENABLE];
			s_d.mfen = pwdata[SPISF_S_MFEN];
			s_d.rate = pwdata[SPISF_S_RATE_HI:SPISF_S_RATE_LO];
		end
		// Status read arms the second step for each flag seen set
		if (rd && hit_s) begin
			s_d.rxf_arm = s_q.rxf;
			s_d.ovr_arm = s_q.ovr;
			s_d.mode_fault_flag_arm = s_q.mode_fault_flag;
		end
		if (clr_rxf) s_d.rxf_arm = 1'b0;
		if (clr_ovr) s_d.ovr_arm = 1'b0;
		if (clr_mode_fault_flag) s_d.mode_fault_flag_arm = 1'b0;
		// Sets win over clears
		if (clr_rxf) s_d.rxf = 1'b0;
		if (clr_ovr) s_d.ovr = 1'b0;
		if (clr_mode_fault_flag) s_d.mode_fault_flag = 1'b0;
		if (set_rxf) begin
			s_d.rxf = 1'b1;
			s_d.rx_buf = rx_byte;
		end
		if (set_ovr) s_d.ovr = 1'b1;
		if (set_mode_fault_flag) s_d.mode_fault_flag = 1'b1;
		// Data write loads transmit buffer and clears empty
		if (wr && hit_d && pstrb[0]) begin
			s_d.tx_buf = pwdata[7:0];
			s_d.tx_load = 1'b1;
			s_d.txe = 1'b0;
		end
		if (set_txe) begin
			s_d.tx_load = 1'b0;
			s_d.tx_load_data = s_q.tx_buf;
			s_d.txe = 1'b1;
		end
		// Baud tick from bus clock, master only
		s_d.sck_tick = 1'b0;
		if (en && mstr) begin
			if (s_q.div_cnt >= 7'(bd - 8'h01)) begin
				s_d.div_cnt = '0;
				s_d.sck_tick = 1'b1;
			end else begin
				s_d.div_cnt = s_q.div_cnt + 7'h01;
			end
		end else begin
			s_d.div_cnt = '0;
		end
		s_d.ss_owned = en && (!mstr || s_q.mfen);
		s_d.is_slave = en && !mstr && !slave_select_n;
		s_d.irq = (s_d.rxf && s_d.ctrl[SPISF_C_RXIE]) ||
			(s_d.txe && s_d.ctrl[SPISF_C_TXIE]) ||
			(s_d.error_irq_enable && (s_d.ovr || s_d.mode_fault_flag));
		s_d.ss_q = slave_select_n;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_q <= '0;
			s_q.ctrl <= SPISF_CTRL_RST;
			s_q.txe <= 1'b1;
			s_q.ss_q <= 1'b1;
		end else begin
			s_q <= s_d;
		end
	end

	assign prdata = s_q.prdata;
	assign pready = s_q.pready;
	assign pslverr = s_q.pslverr;
	assign tx_byte = s_q.tx_load_data;
	assign tx_byte_valid = s_q.tx_load;
	assign sck_tick = s_q.sck_tick;
	assign ss_pin_owned = s_q.ss_owned;
	assign slave_mode = s_q.is_slave;
	assign irq = s_q.irq;
	assign ctrl_out = s_q.ctrl;

	chk_rxf_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_byte_done && !s_q.rxf
		|=> s_q.rxf && s_q.rx_buf == $past(rx_byte))
		else $error("rx full not set");

	chk_rx_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_q.rxf && s_q.ctrl[SPISF_C_RXIE]
		|-> irq)
		else $error("rx irq missing");

	chk_rxf_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd && hit_d && s_q.rxf_arm && !rx_byte_done
		|=> !s_q.rxf)
		else $error("rx full not cleared");

	chk_rxf_noarm: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd && hit_d && !s_q.rxf_arm && s_q.rxf
		|=> s_q.rxf)
		else $error("rx full cleared without status read");

	chk_err_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		irq && !s_q.error_irq_enable
		|-> (s_q.rxf && s_q.ctrl[SPISF_C_RXIE]) || (s_q.txe && s_q.ctrl[SPISF_C_TXIE]))
		else $error("error irq not gated");

	chk_err_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_q.error_irq_enable && (s_q.ovr || s_q.mode_fault_flag)
		|-> irq)
		else $error("error irq missing");

	chk_ovr_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_byte_done && s_q.rxf
		|=> s_q.ovr)
		else $error("overrun not set");

	chk_ovr_keep: assert property (
		@(posedge pclk) disable iff (!presetn)
		rx_byte_done && s_q.rxf
		|=> $stable(s_q.rx_buf))
		else $error("overrun replaced old byte");

	chk_ovr_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		rd && hit_d && s_q.ovr_arm && !(rx_byte_done && s_q.rxf)
		|=> !s_q.ovr)
		else $error("overrun not cleared");

	chk_mode_fault_flag_slave: assert property (
		@(posedge pclk) disable iff (!presetn)
		en && !mstr && s_q.mfen && transfer_active && slave_select_n
		|=> s_q.mode_fault_flag)
		else $error("slave fault missed");

	chk_mode_fault_flag_master: assert property (
		@(posedge pclk) disable iff (!presetn)
		en && mstr && s_q.mfen && !slave_select_n
		|=> s_q.mode_fault_flag)
		else $error("master fault missed");

	chk_mode_fault_flag_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_c && s_q.mode_fault_flag_arm && !set_mode_fault_flag
		|=> !s_q.mode_fault_flag)
		else $error("fault not cleared");

	chk_txe_set: assert property (
		@(posedge pclk) disable iff (!presetn)
		tx_take && tx_byte_valid
		|=> s_q.txe && tx_byte == $past(s_q.tx_buf))
		else $error("tx empty not set");

	chk_tx_irq: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_q.txe && s_q.ctrl[SPISF_C_TXIE]
		|-> irq)
		else $error("tx irq missing");

	chk_txe_clear: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_d && !set_txe
		|=> !s_q.txe)
		else $error("tx empty not cleared");

	chk_mode_fault_flag_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		s_q.mode_fault_flag && !clr_mode_fault_flag
		|=> s_q.mode_fault_flag)
		else $error("fault lost");

	chk_mode_fault_flag_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		!s_q.mode_fault_flag && !s_q.mfen
		|=> !s_q.mode_fault_flag)
		else $error("fault set while detect off");

	chk_owned_master: assert property (
		@(posedge pclk) disable iff (!presetn)
		en && mstr
		|=> ss_pin_owned == $past(s_q.mfen))
		else $error("master select ownership wrong");

	chk_master_ignore: assert property (
		@(posedge pclk) disable iff (!presetn)
		en && mstr && !s_q.mfen && !s_q.mode_fault_flag
		|=> !s_q.mode_fault_flag)
		else $error("master select level not ignored");

	chk_owned_slave: assert property (
		@(posedge pclk) disable iff (!presetn)
		en && !mstr
		|=> ss_pin_owned)
		else $error("slave select not owned");

	chk_div_two: assert property (
		@(posedge pclk) disable iff (!presetn)
		(sck_tick && s_q.rate == 2'b00 && en && mstr) ##1 (s_q.rate == 2'b00 && en && mstr)
		|=> sck_tick)
		else $error("divide by two wrong");

	chk_div_gap: assert property (
		@(posedge pclk) disable iff (!presetn)
		sck_tick
		|=> !sck_tick)
		else $error("tick too close");

	chk_slave_tick: assert property (
		@(posedge pclk) disable iff (!presetn)
		!mstr && $past(!mstr)
		|-> !sck_tick)
		else $error("slave tick");

	chk_data_split: assert property (
		@(posedge pclk) disable iff (!presetn)
		wr && hit_d && !rx_byte_done
		|=> $stable(s_q.rx_buf))
		else $error("data write reached receive buffer");

	chk_slave_mode: assert property (
		@(posedge pclk) disable iff (!presetn)
		en && !mstr && !slave_select_n
		|=> slave_mode)
		else $error("slave mode not entered");

	cov_overrun: cover property (
		@(posedge pclk) disable iff (!presetn) set_ovr);

	cov_mode_fault_flag_clr: cover property (
		@(posedge pclk) disable iff (!presetn) clr_mode_fault_flag);

	cov_tx_cycle: cover property (
		@(posedge pclk) disable iff (!presetn) set_txe);

	cov_rx_clear: cover property (
		@(posedge pclk) disable iff (!presetn) clr_rxf);

	cov_mode_fault_flag_master: cover property (
		@(posedge pclk) disable iff (!presetn) set_mode_fault_flag && mstr);
endmodule : spisf_core
